//--- rtl/ldocrb_params.svh
// Constants for the regulator control register bank.
`ifndef LDOCRB_PARAMS_SVH
`define LDOCRB_PARAMS_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define LDOCRB_ADDR_A_VOLT 8'h03
`define LDOCRB_ADDR_RSVD 8'h40
`define LDOCRB_ADDR_B_CTRL 8'h41
`define LDOCRB_ADDR_C_CTRL 8'h42
`define LDOCRB_ADDR_DIS_STAT 8'h43

// ****************************************************************
// Writable bit masks (all other bits are read-only)
// ****************************************************************
`define LDOCRB_WMASK_A_VOLT 8'h7f
`define LDOCRB_WMASK_RSVD 8'h20
`define LDOCRB_WMASK_BC_CTRL 8'h3f
`define LDOCRB_WMASK_DIS_STAT 8'h1e

// ****************************************************************
// Field positions
// ****************************************************************
`define LDOCRB_A_CODE_MSB 5
`define LDOCRB_A_RANGE_BIT 6
`define LDOCRB_BC_CODE_MSB 4
`define LDOCRB_BC_ENABLE_BIT 5
`define LDOCRB_DIS_A_BIT 2
`define LDOCRB_DIS_B_BIT 3
`define LDOCRB_DIS_C_BIT 4
`define LDOCRB_PG_A_BIT 5
`define LDOCRB_PG_B_BIT 6
`define LDOCRB_PG_C_BIT 7

// ****************************************************************
// Reset values (neutral defaults, overridable per instance)
// ****************************************************************
`define LDOCRB_RST_A_VOLT 8'h00
`define LDOCRB_RST_RSVD 8'h00
`define LDOCRB_RST_B_CTRL 8'h00
`define LDOCRB_RST_C_CTRL 8'h00
`define LDOCRB_RST_DIS_STAT 8'h00

// ****************************************************************
// Voltage decode constants
// ****************************************************************
`define LDOCRB_HI_BASE_MV 12'h4e2
`define LDOCRB_HI_STEP_MV 12'h032
`define LDOCRB_HI_TOP_COL 2'h3
`define LDOCRB_HI_TOP_ROWS 3'h0

`endif

//--- rtl/ldocrb_pkg.sv
// Types shared by the regulator control register bank.
package ldocrb_pkg;
    typedef logic [7:0] ldocrb_addr_t;
    typedef logic [7:0] ldocrb_byte_t;
    typedef logic [11:0] ldocrb_mv_t;
    typedef logic [5:0] ldocrb_code_t;
endpackage

//--- rtl/ldocrb_vlut.sv
// Voltage code to millivolt lookup with a registered result.
`timescale 1ns/100ps
`include "ldocrb_params.svh"
module ldocrb_vlut #(
    parameter bit IS_LDO_A = 1'b0
) (
    input wire logic mclk,
    input wire logic rst_sync_b,
    input wire logic clk_en,
    input wire logic range_sel,
    input wire ldocrb_pkg::ldocrb_code_t code,
    output ldocrb_pkg::ldocrb_mv_t target_mv,
    output logic target_valid
);
    import ldocrb_pkg::*;

    // ****************************************************************
    // Tables, indexed by the code itself (column-major)
    // ****************************************************************
    localparam ldocrb_mv_t LOW_TBL [64] = '{
        12'h285, 12'h29e, 12'h2b7, 12'h2d0, 12'h2e9, 12'h302, 12'h31b,
        12'h334, 12'h34d, 12'h366, 12'h37f, 12'h398, 12'h3b6, 12'h3cf,
        12'h3e8, 12'h401,
        12'h41a, 12'h433, 12'h44c, 12'h465, 12'h47e, 12'h497, 12'h4b0,
        12'h4c9, 12'h4e7, 12'h500, 12'h519, 12'h532, 12'h54b, 12'h564,
        12'h57d, 12'h596,
        12'h5af, 12'h5c8, 12'h5e1, 12'h5fa, 12'h613, 12'h631, 12'h64a,
        12'h663, 12'h67c, 12'h695, 12'h6ae, 12'h6c7, 12'h6e0, 12'h6f9,
        12'h712, 12'h72b,
        12'h744, 12'h762, 12'h77b, 12'h794, 12'h7ad, 12'h7c6, 12'h7df,
        12'h7f8, 12'h811, 12'h82a, 12'h843, 12'h85c, 12'h875, 12'h88e,
        12'h898, 12'h8c5
    };

    localparam ldocrb_mv_t BC_TBL [32] = '{
        12'h578, 12'h5dc, 12'h640, 12'h6a4, 12'h708, 12'h76c, 12'h7d0,
        12'h834,
        12'h866, 12'h898, 12'h8ca, 12'h8fc, 12'h92e, 12'h960, 12'h992,
        12'h9c4,
        12'h9f6, 12'ha28, 12'ha5a, 12'ha8c, 12'habe, 12'haf0, 12'hb22,
        12'hb54,
        12'hbb8, 12'hc1c, 12'hc80, 12'hce4, 12'hd48, 12'hdac, 12'he10,
        12'he74
    };

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire ldocrb_mv_t hi_mv;
    wire logic hi_top_col;
    wire logic hi_code_ok;
    wire ldocrb_mv_t sel_mv;
    wire logic sel_valid;

    // The high table is a uniform step from its base value.
    assign hi_mv = `LDOCRB_HI_BASE_MV
        + ldocrb_mv_t'({6'h00, code} * `LDOCRB_HI_STEP_MV); // [RULE_03]
    assign hi_top_col = (code[5:4] == `LDOCRB_HI_TOP_COL);
    assign hi_code_ok = !hi_top_col
        || (code[3:1] == `LDOCRB_HI_TOP_ROWS); // [RULE_04]
    assign sel_valid = !IS_LDO_A || !range_sel || hi_code_ok;
    assign sel_mv = !IS_LDO_A ? BC_TBL[code[4:0]] // [RULE_05]
        : (range_sel ? hi_mv : LOW_TBL[code]); // [RULE_02]

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            target_mv <= 12'h000;
            target_valid <= 1'b0;
        end else if (clk_en) begin
            target_mv <= sel_valid ? sel_mv : 12'h000; // [RULE_04]
            target_valid <= sel_valid;
        end
    end
endmodule

//--- rtl/ldocrb_top.sv
// Control and status register bank for three linear regulators.
`timescale 1ns/100ps
`include "ldocrb_params.svh"

// Summary of operation
// [RULE_01] Address 03h bits 5:0 hold the read/write ldo_a voltage code.
// [RULE_02] Address 03h bit 6 picks the low or high ldo_a voltage table.
// [RULE_03] ldo_a code bits 5:4 pick the column, bits 3:0 the row.
// [RULE_04] High range top column: only rows 0000 and 0001 are valid.
// [RULE_05] ldo_b/ldo_c codes: bits 4:3 pick the column, bits 2:0 the row.
// [RULE_06] ldo_b code at 41h bits 4:0, ldo_c code at 42h bits 4:0.
// [RULE_07] Bit 5 of 41h enables ldo_b when set.
// [RULE_08] Bit 5 of 42h enables ldo_c when set.
// [RULE_09] Bits 2, 3, 4 of 43h enable discharge for ldo_a, ldo_b, ldo_c.
// [RULE_10] Bits 5, 6, 7 of 43h report power good, read-only.
// [RULE_11] Reserved bits of 03h, 40h, 41h, 42h, 43h ignore writes.
// [RULE_12] Host writes 40h bit 5 and 43h bit 1 only with defaults.
// [RULE_13] Write-exact bits are stored read/write, host writes defaults.
// [RULE_14] ldo_a on when master enable low or hold high; gates b and c.
// [RULE_15] Power good clears while the under-voltage comparator trips.
// [RULE_16] A shut-down regulator with discharge enabled drives discharge.
// [RULE_17] Every register reset value is a module parameter. 43h bits 7:5 (power good) reset to 0 in pg_reg instead.
module ldocrb_top #(
    parameter ldocrb_pkg::ldocrb_byte_t RST_A_VOLT = `LDOCRB_RST_A_VOLT,
    parameter ldocrb_pkg::ldocrb_byte_t RST_RSVD = `LDOCRB_RST_RSVD,
    parameter ldocrb_pkg::ldocrb_byte_t RST_B_CTRL = `LDOCRB_RST_B_CTRL,
    parameter ldocrb_pkg::ldocrb_byte_t RST_C_CTRL = `LDOCRB_RST_C_CTRL,
    parameter ldocrb_pkg::ldocrb_byte_t RST_DIS_STAT = `LDOCRB_RST_DIS_STAT
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire ldocrb_pkg::ldocrb_addr_t reg_addr,
    input wire ldocrb_pkg::ldocrb_byte_t reg_wdata,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    output ldocrb_pkg::ldocrb_byte_t reg_rdata,
    output logic reg_rd_valid,
    input wire logic master_enable_n,
    input wire logic power_hold,
    input wire logic ldo_a_uv,
    input wire logic ldo_b_uv,
    input wire logic ldo_c_uv,
    output logic ldo_a_enable_out,
    output logic ldo_b_enable_out,
    output logic ldo_c_enable_out,
    output logic ldo_a_discharge_out,
    output logic ldo_b_discharge_out,
    output logic ldo_c_discharge_out,
    output ldocrb_pkg::ldocrb_mv_t ldo_a_target_mv,
    output logic ldo_a_target_valid,
    output ldocrb_pkg::ldocrb_mv_t ldo_b_target_mv,
    output ldocrb_pkg::ldocrb_mv_t ldo_c_target_mv
);
    import ldocrb_pkg::*;

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_meta_reg;
    logic rst_sync_b;

    // Reset asserts at once and releases two clock edges later.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_b <= rst_meta_reg;
        end
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // Order: master enable, hold, ldo_a/b/c under-voltage.
    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;
    wire logic [4:0] pin_raw;

    assign pin_raw = {ldo_c_uv, ldo_b_uv, ldo_a_uv, power_hold,
        master_enable_n};

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pin_meta_reg <= 5'h01;
            pin_sync_reg <= 5'h01;
        end else if (clk_en) begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    wire logic master_enable_n_s;
    wire logic power_hold_s;
    wire logic [2:0] uv_s;

    assign master_enable_n_s = pin_sync_reg[0];
    assign power_hold_s = pin_sync_reg[1];
    assign uv_s = pin_sync_reg[4:2];

    // ****************************************************************
    // Address decode
    // ****************************************************************
    wire logic hit_a_volt;
    wire logic hit_rsvd;
    wire logic hit_b_ctrl;
    wire logic hit_c_ctrl;
    wire logic hit_dis_stat;
    wire logic wr_a_volt;
    wire logic wr_rsvd;
    wire logic wr_b_ctrl;
    wire logic wr_c_ctrl;
    wire logic wr_dis_stat;

    assign hit_a_volt = (reg_addr == `LDOCRB_ADDR_A_VOLT);
    assign hit_rsvd = (reg_addr == `LDOCRB_ADDR_RSVD);
    assign hit_b_ctrl = (reg_addr == `LDOCRB_ADDR_B_CTRL);
    assign hit_c_ctrl = (reg_addr == `LDOCRB_ADDR_C_CTRL);
    assign hit_dis_stat = (reg_addr == `LDOCRB_ADDR_DIS_STAT);
    assign wr_a_volt = reg_wr_en && hit_a_volt;
    assign wr_rsvd = reg_wr_en && hit_rsvd;
    assign wr_b_ctrl = reg_wr_en && hit_b_ctrl;
    assign wr_c_ctrl = reg_wr_en && hit_c_ctrl;
    assign wr_dis_stat = reg_wr_en && hit_dis_stat;

    // ****************************************************************
    // Register storage
    // ****************************************************************
    // Only bits in the write mask change; the rest keep their reset
    // value and read back as the parameter bits, except 43h bits 7:5 (power good).
    ldocrb_byte_t a_volt_reg;
    ldocrb_byte_t rsvd_reg;
    ldocrb_byte_t b_ctrl_reg;
    ldocrb_byte_t c_ctrl_reg;
    ldocrb_byte_t dis_ctrl_reg;
    ldocrb_byte_t a_volt_next;
    ldocrb_byte_t rsvd_next;
    ldocrb_byte_t b_ctrl_next;
    ldocrb_byte_t c_ctrl_next;
    ldocrb_byte_t dis_ctrl_next;

    assign a_volt_next = (a_volt_reg & ~`LDOCRB_WMASK_A_VOLT)
        | (reg_wdata & `LDOCRB_WMASK_A_VOLT); // [RULE_01] [RULE_02]
    assign rsvd_next = (rsvd_reg & ~`LDOCRB_WMASK_RSVD)
        | (reg_wdata & `LDOCRB_WMASK_RSVD); // [RULE_11] [RULE_13]
    assign b_ctrl_next = (b_ctrl_reg & ~`LDOCRB_WMASK_BC_CTRL)
        | (reg_wdata & `LDOCRB_WMASK_BC_CTRL); // [RULE_06] [RULE_07]
    assign c_ctrl_next = (c_ctrl_reg & ~`LDOCRB_WMASK_BC_CTRL)
        | (reg_wdata & `LDOCRB_WMASK_BC_CTRL); // [RULE_06] [RULE_08]
    assign dis_ctrl_next = (dis_ctrl_reg & ~`LDOCRB_WMASK_DIS_STAT)
        | (reg_wdata & `LDOCRB_WMASK_DIS_STAT); // [RULE_09] [RULE_12]

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            a_volt_reg <= RST_A_VOLT; // [RULE_17]
            rsvd_reg <= RST_RSVD;
            b_ctrl_reg <= RST_B_CTRL;
            c_ctrl_reg <= RST_C_CTRL;
            dis_ctrl_reg <= RST_DIS_STAT;
        end else if (clk_en) begin
            if (wr_a_volt) begin
                a_volt_reg <= a_volt_next;
            end
            if (wr_rsvd) begin
                rsvd_reg <= rsvd_next;
            end
            if (wr_b_ctrl) begin
                b_ctrl_reg <= b_ctrl_next;
            end
            if (wr_c_ctrl) begin
                c_ctrl_reg <= c_ctrl_next;
            end
            if (wr_dis_stat) begin
                dis_ctrl_reg <= dis_ctrl_next; // [RULE_11]
            end
        end
    end

    // ****************************************************************
    // Power good status
    // ****************************************************************
    // Status follows the synchronised comparators, so it is low for as
    // long as an output sits below its threshold.
    logic [2:0] pg_reg;

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pg_reg <= 3'h0;
        end else if (clk_en) begin
            pg_reg <= ~uv_s; // [RULE_15]
        end
    end

    // ****************************************************************
    // Regulator control
    // ****************************************************************
    wire logic sys_on;
    wire logic b_on;
    wire logic c_on;

    assign sys_on = !master_enable_n_s || power_hold_s; // [RULE_14]
    assign b_on = sys_on && b_ctrl_reg[`LDOCRB_BC_ENABLE_BIT]; // [RULE_07]
    assign c_on = sys_on && c_ctrl_reg[`LDOCRB_BC_ENABLE_BIT]; // [RULE_08]

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ldo_a_enable_out <= 1'b0;
            ldo_b_enable_out <= 1'b0;
            ldo_c_enable_out <= 1'b0;
            ldo_a_discharge_out <= 1'b0;
            ldo_b_discharge_out <= 1'b0;
            ldo_c_discharge_out <= 1'b0;
        end else if (clk_en) begin
            ldo_a_enable_out <= sys_on; // [RULE_14]
            ldo_b_enable_out <= b_on;
            ldo_c_enable_out <= c_on;
            ldo_a_discharge_out <= !sys_on
                && dis_ctrl_reg[`LDOCRB_DIS_A_BIT]; // [RULE_16]
            ldo_b_discharge_out <= !b_on
                && dis_ctrl_reg[`LDOCRB_DIS_B_BIT]; // [RULE_16]
            ldo_c_discharge_out <= !c_on
                && dis_ctrl_reg[`LDOCRB_DIS_C_BIT]; // [RULE_16]
        end
    end

    // ****************************************************************
    // Voltage targets
    // ****************************************************************
    wire ldocrb_code_t a_code;
    wire ldocrb_code_t b_code;
    wire ldocrb_code_t c_code;

    assign a_code = a_volt_reg[`LDOCRB_A_CODE_MSB:0]; // [RULE_03]
    assign b_code = {1'b0, b_ctrl_reg[`LDOCRB_BC_CODE_MSB:0]}; // [RULE_05]
    assign c_code = {1'b0, c_ctrl_reg[`LDOCRB_BC_CODE_MSB:0]}; // [RULE_05]

    ldocrb_vlut #(
        .IS_LDO_A(1'b1)
    ) u_lut_a (
        .mclk(mclk),
        .rst_sync_b(rst_sync_b),
        .clk_en(clk_en),
        .range_sel(a_volt_reg[`LDOCRB_A_RANGE_BIT]),
        .code(a_code),
        .target_mv(ldo_a_target_mv),
        .target_valid(ldo_a_target_valid)
    );

    ldocrb_vlut #(
        .IS_LDO_A(1'b0)
    ) u_lut_b (
        .mclk(mclk),
        .rst_sync_b(rst_sync_b),
        .clk_en(clk_en),
        .range_sel(1'b0),
        .code(b_code),
        .target_mv(ldo_b_target_mv),
        .target_valid()
    );

    ldocrb_vlut #(
        .IS_LDO_A(1'b0)
    ) u_lut_c (
        .mclk(mclk),
        .rst_sync_b(rst_sync_b),
        .clk_en(clk_en),
        .range_sel(1'b0),
        .code(c_code),
        .target_mv(ldo_c_target_mv),
        .target_valid()
    );

    // ****************************************************************
    // Read path
    // ****************************************************************
    wire ldocrb_byte_t dis_stat_view;
    wire ldocrb_byte_t rd_mux;

    assign dis_stat_view = {pg_reg[2], pg_reg[1], pg_reg[0],
        dis_ctrl_reg[4:0]}; // [RULE_10]
    // Unmapped addresses read as zero.
    assign rd_mux = hit_a_volt ? a_volt_reg
        : hit_rsvd ? rsvd_reg
        : hit_b_ctrl ? b_ctrl_reg
        : hit_c_ctrl ? c_ctrl_reg
        : hit_dis_stat ? dis_stat_view
        : 8'h00;

    always_ff @(posedge mclk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            reg_rdata <= 8'h00;
            reg_rd_valid <= 1'b0;
        end else if (clk_en) begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata <= rd_mux;
            end
        end
    end
endmodule

//--- tb/ldocrb_host.sv
// Host model driving single-byte cycles on the register strobe port.
`timescale 1ns/100ps
module ldocrb_host #(
    parameter bit WE40 = 1'b0,
    parameter bit WE43 = 1'b0
) (
    input wire logic mclk,
    output ldocrb_pkg::ldocrb_addr_t reg_addr,
    output ldocrb_pkg::ldocrb_byte_t reg_wdata,
    output logic reg_wr_en,
    output logic reg_rd_en
);
    import ldocrb_pkg::*;
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
    end
    // Write-exact bits always leave with their default value.
    // Released lines carry the inverse of the last value.
    task automatic cycle(input ldocrb_addr_t a, input ldocrb_byte_t d,
                         input logic w);
        ldocrb_byte_t x;
        x = d;
        if (w && a == 8'h40) x[5] = WE40;
        if (w && a == 8'h43) x[1] = WE43;
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= x;
        reg_wr_en <= w;
        reg_rd_en <= !w;
        @(posedge mclk);
        reg_wr_en <= 1'b0;
        reg_rd_en <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~x;
    endtask
endmodule

//--- tb/ldocrb_chk.sv
// Port-level checker for the regulator control register bank.
`timescale 1ns/100ps
module ldocrb_chk #(
    parameter ldocrb_pkg::ldocrb_byte_t RST_RSVD = 8'h00
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire ldocrb_pkg::ldocrb_addr_t reg_addr,
    input wire ldocrb_pkg::ldocrb_byte_t reg_wdata,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire ldocrb_pkg::ldocrb_byte_t reg_rdata,
    input wire logic reg_rd_valid,
    input wire logic master_enable_n,
    input wire logic power_hold,
    input wire logic ldo_a_uv,
    input wire logic ldo_b_uv,
    input wire logic ldo_c_uv,
    input wire logic ldo_a_enable_out,
    input wire logic ldo_b_enable_out,
    input wire logic ldo_c_enable_out,
    input wire logic ldo_a_discharge_out,
    input wire logic ldo_b_discharge_out,
    input wire logic ldo_c_discharge_out
);
    import ldocrb_pkg::*;
    logic [4:0] pins_reg;
    logic [2:0] quiet_reg;
    wire logic [4:0] pins = {master_enable_n, power_hold,
                             ldo_c_uv, ldo_b_uv, ldo_a_uv};
    // Calm means pins steady long enough to pass the synchronisers.
    wire logic calm = (quiet_reg == 3'h7) && (pins == pins_reg);
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pins_reg <= 5'h00;
            quiet_reg <= 3'h0;
        end else begin
            pins_reg <= pins;
            if (!clk_en || pins != pins_reg) quiet_reg <= 3'h0;
            else if (quiet_reg != 3'h7) quiet_reg <= quiet_reg + 3'h1;
        end
    end
    default clocking dcb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    sequence s_wr(a);
        clk_en && reg_wr_en && reg_addr == a;
    endsequence
    a_rd_answer: assert property (
        clk_en && reg_rd_en |=> reg_rd_valid)
        else $error("read strobe not answered next cycle");
    a_rdata_hold: assert property (
        !reg_rd_valid |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_ro_rsvd: assert property (
        clk_en && reg_rd_en && reg_addr == 8'h40
        |=> (reg_rdata & 8'hdf) == (RST_RSVD & 8'hdf))
        else $error("read-only bits of 40h wrong");
    a_b_follows: assert property (s_wr(8'h41) ##1 clk_en
        |=> ldo_b_enable_out
        == (ldo_a_enable_out && $past(reg_wdata[5], 2)))
        else $error("ldo_b enable does not follow its bit");
    a_c_follows: assert property (s_wr(8'h42) ##1 clk_en
        |=> ldo_c_enable_out
        == (ldo_a_enable_out && $past(reg_wdata[5], 2)))
        else $error("ldo_c enable does not follow its bit");
    a_dis_write: assert property (s_wr(8'h43) ##1 clk_en
        |=> ldo_a_discharge_out
        == (!ldo_a_enable_out && $past(reg_wdata[2], 2)))
        else $error("ldo_a discharge does not follow its bit");
    a_dis_excl: assert property (
        !(ldo_a_discharge_out && ldo_a_enable_out)
        && !(ldo_b_discharge_out && ldo_b_enable_out)
        && !(ldo_c_discharge_out && ldo_c_enable_out))
        else $error("discharge on a running regulator");
    a_a_pins: assert property (calm
        |-> ldo_a_enable_out == (!master_enable_n || power_hold))
        else $error("ldo_a enable wrong for the pins");
    a_pg_read: assert property (
        clk_en && reg_rd_en && reg_addr == 8'h43 && calm
        |=> reg_rdata[7:5] == ~$past(pins[2:0]))
        else $error("power good bits wrong");
endmodule
bind ldocrb_top ldocrb_chk #(.RST_RSVD(RST_RSVD)) u_chk (.*);

//--- tb/ldocrb_top_tb.sv
// Self-checking testbench for the regulator control register bank.
`timescale 1ns/100ps
module ldocrb_top_tb;
    import ldocrb_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic master_enable_n = 1'b1;
    logic power_hold = 1'b0;
    logic ldo_a_uv = 1'b0, ldo_b_uv = 1'b0, ldo_c_uv = 1'b0;
    ldocrb_addr_t reg_addr;
    ldocrb_byte_t reg_wdata, reg_rdata;
    logic reg_wr_en, reg_rd_en, reg_rd_valid, ldo_a_target_valid;
    logic ldo_a_enable_out, ldo_b_enable_out, ldo_c_enable_out;
    logic ldo_a_discharge_out, ldo_b_discharge_out, ldo_c_discharge_out;
    ldocrb_mv_t ldo_a_target_mv, ldo_b_target_mv, ldo_c_target_mv;
    ldocrb_byte_t exp_q[$];
    ldocrb_byte_t sh[6];
    ldocrb_addr_t adr[6] = '{8'h03, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44};
    ldocrb_byte_t msk[6] = '{8'h7f, 8'h00, 8'h3f, 8'h3f, 8'h1c, 8'h00};
    logic [6:0] ac[8] = '{7'h00, 7'h3f, 7'h25, 7'h31,
                          7'h40, 7'h70, 7'h71, 7'h72};
    ldocrb_mv_t am[8] = '{12'h285, 12'h8c5, 12'h631, 12'h762,
                          12'h4e2, 12'he42, 12'he74, 12'h000};
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [15:0] lfsr = 16'h83dc;
    always #25 mclk = ~mclk;
    ldocrb_top dut (.*);
    ldocrb_host host (.*);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] nxt(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic ldocrb_mv_t bc_mv(input logic [4:0] c);
        case (c[4:3])
            2'h0: return 12'h578 + 12'h064 * c[2:0];
            2'h1: return 12'h866 + 12'h032 * c[2:0];
            2'h2: return 12'h9f6 + 12'h032 * c[2:0];
            default: return 12'hbb8 + 12'h064 * c[2:0];
        endcase
    endfunction
    task automatic chk(input string s, input logic [11:0] g, e);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %0t: %s got %h exp %h", $time, s, g, e);
        end
    endtask
    task automatic chk_byte(input ldocrb_byte_t g, e);
        chk("read", {4'h0, g}, {4'h0, e});
    endtask
    task automatic rd(input int i);
        ldocrb_byte_t e;
        e = sh[i];
        if (i == 4) e[7:5] = ~{ldo_c_uv, ldo_b_uv, ldo_a_uv};
        exp_q.push_back(e);
        host.cycle(adr[i], 8'h00, 1'b0);
    endtask
    task automatic wr(input int i, input ldocrb_byte_t d);
        sh[i] = d & msk[i];
        host.cycle(adr[i], d, 1'b1);
    endtask
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (10) @(posedge mclk);
        for (int i = 0; i < 6; i++) sh[i] = 8'h00;
    endtask
    task automatic settle();
        @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic test_done();
        $display("Checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ****************************************
    // Read monitor and timeout
    // ****************************************
    always @(negedge mclk) begin
        if (reg_rd_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("spurious read", 12'h001, 12'h000);
            end else begin
                chk_byte(reg_rdata, exp_q.pop_front());
            end
        end
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 6000) begin
            err_count++;
            test_done();
        end
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        do_reset();
        for (int i = 0; i < 6; i++) rd(i);
        $display("Test reset values done");
        for (int i = 0; i < 6; i++) begin
            lfsr = nxt(lfsr);
            wr(i, lfsr[7:0]);
            rd(i);
        end
        $display("Test register access done");
        for (int i = 0; i < 8; i++) begin
            wr(0, {1'b0, ac[i]});
            settle();
            chk("a mv", ldo_a_target_mv, am[i]);
            chk("a ok", {11'h0, ldo_a_target_valid},
                {11'h0, i != 7});
        end
        $display("Test ldo_a decode done");
        @(posedge mclk);
        power_hold <= 1'b1;
        for (int i = 0; i < 32; i++) begin
            lfsr = nxt(lfsr);
            wr(2, {lfsr[7:5], i[4:0]});
            wr(3, {lfsr[2:0], ~i[4:0]});
            settle();
            chk("b mv", ldo_b_target_mv, bc_mv(i[4:0]));
            chk("c mv", ldo_c_target_mv, bc_mv(~i[4:0]));
            rd(2);
        end
        $display("Test ldo_b ldo_c decode done");
        @(posedge mclk);
        clk_en <= 1'b0;
        host.cycle(adr[2], 8'h1f, 1'b1);
        @(posedge mclk);
        clk_en <= 1'b1;
        rd(2);
        $display("Test clock enable done");
        wr(2, 8'h20);
        wr(3, 8'h00);
        wr(4, 8'h1c);
        for (int k = 0; k < 4; k++) begin
            lfsr = nxt(lfsr);
            @(posedge mclk);
            {master_enable_n, power_hold} <= k[1:0];
            {ldo_c_uv, ldo_b_uv, ldo_a_uv} <= lfsr[2:0];
            repeat (8) @(posedge mclk);
            @(negedge mclk);
            chk("outs", {6'h00, ldo_a_enable_out, ldo_b_enable_out,
                ldo_c_enable_out, ldo_a_discharge_out, ldo_b_discharge_out,
                ldo_c_discharge_out}, (k == 2) ? 12'h007 : 12'h031);
            rd(4);
        end
        $display("Test enables and discharge done");
        // Let the last read answer land before reset clears it.
        @(posedge mclk);
        do_reset();
        for (int i = 0; i < 6; i++) rd(i);
        $display("Test second reset done");
        repeat (4) @(posedge mclk);
        chk("pending", 12'(exp_q.size()), 12'h000);
        test_done();
    end
endmodule
